// ---- mbsf_params.svh ----
`ifndef MBSF_PARAMS_SVH
`define MBSF_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and timing
`define MBSF_CLK_PERIOD_NS 10
`define MBSF_ASCII_GAP_S 1
`define MBSF_ASCII_GAP_CYCLES ((`MBSF_ASCII_GAP_S * 1000000000) / `MBSF_CLK_PERIOD_NS)
// One character time on the line; plain default, set to the real line rate
`define MBSF_CHAR_TIME_NS 1146000
`define MBSF_T15_TENTHS 15
`define MBSF_T35_TENTHS 35
`define MBSF_RTU_T15_CYCLES \
   ((`MBSF_CHAR_TIME_NS * `MBSF_T15_TENTHS) / (10 * `MBSF_CLK_PERIOD_NS))
`define MBSF_RTU_T35_CYCLES \
   ((`MBSF_CHAR_TIME_NS * `MBSF_T35_TENTHS + 10 * `MBSF_CLK_PERIOD_NS - 1) / \
    (10 * `MBSF_CLK_PERIOD_NS))

////////////////////////////////////////////////////////////////////////////////
// Characters
`define MBSF_CH_COLON 8'h3A
`define MBSF_CH_CR 8'h0D
`define MBSF_CH_LF 8'h0A
`define MBSF_CH_0 8'h30
`define MBSF_CH_9 8'h39
`define MBSF_CH_UA 8'h41
`define MBSF_CH_UF 8'h46
`define MBSF_CH_LA 8'h61
`define MBSF_CH_LF_HEX 8'h66
`define MBSF_HEX_ALPHA_OFS 8'h37
`define MBSF_HEX_LOWER_OFS 8'h57

////////////////////////////////////////////////////////////////////////////////
// Function codes, error flag, exception codes
`define MBSF_FC_READ_COILS 8'h01
`define MBSF_FC_READ_INPUTS 8'h02
`define MBSF_FC_READ_HOLDING 8'h03
`define MBSF_FC_READ_INREGS 8'h04
`define MBSF_FC_WRITE_COIL 8'h05
`define MBSF_FC_WRITE_REG 8'h06
`define MBSF_FC_WRITE_COILS 8'h0F
`define MBSF_FC_WRITE_REGS 8'h10
`define MBSF_ERR_FLAG 8'h80
`define MBSF_READ_COILS_ERR 8'h81
`define MBSF_EXC_NONE 8'h00
`define MBSF_EXC_ILLEGAL_FUNC 8'h01
`define MBSF_EXC_BAD_ADDR 8'h02
`define MBSF_EXC_BAD_VALUE 8'h03
`define MBSF_EXC_SERVER_FAULT 8'h04
`define MBSF_EXC_BUSY_RETRY 8'h05
`define MBSF_EXC_DELAYED 8'h06

////////////////////////////////////////////////////////////////////////////////
// Limits and layout
`define MBSF_MAX_BITS_READ 16'h07D0
`define MBSF_MAX_WORDS_READ 16'h007D
`define MBSF_MAX_BITS_WRITE 16'h07B0
`define MBSF_MAX_WORDS_WRITE 16'h0078
`define MBSF_STATION_MIN 8'h01
`define MBSF_STATION_MAX 8'h1F
`define MBSF_COIL_COUNT 16'h0800
`define MBSF_HDR_LEN 8'h06
`define MBSF_RTU_CHK_LEN 8'h02
`define MBSF_ASCII_CHK_LEN 8'h01
`define MBSF_CRC_PRESET 16'hFFFF
`define MBSF_CRC_POLY 16'hA001

`endif

// ---- mbsf_pkg.sv ----
package mbsf_pkg;

   typedef enum logic [2:0] {
      T_IDLE,
      T_GAP,
      T_COLON,
      T_HEAD,
      T_COIL,
      T_CHK,
      T_CR,
      T_LF
   } mbsf_tx_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mbsf_char_t;

   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] qty;
   } mbsf_req_t;

   typedef struct packed {
      logic rx_on;
      logic hi_ok;
      logic [3:0] hi_nib;
      logic got_cr;
      logic [5:0][7:0] buf_b;
      logic [7:0] len;
      logic [15:0] crc;
      logic [7:0] lrc;
      logic [31:0] gap;
      mbsf_tx_state_t txs;
      logic nib;
      logic [7:0] idx;
      logic rsp_exc;
      logic [7:0] rsp_sta;
      logic [7:0] rsp_func;
      logic [7:0] rsp_code;
      logic [15:0] rsp_qty;
      logic [15:0] coil_addr;
      logic [15:0] tcrc;
      logic [7:0] tlrc;
      mbsf_char_t tx;
      logic req_valid;
      mbsf_req_t req;
   } mbsf_state_t;

endpackage : mbsf_pkg

// ---- mbsf_crc16_step.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mbsf_params.svh"

module mbsf_crc16_step (
   // Running check in and out
   input wire logic [15:0] crc_i,
   input wire logic [7:0] data_i,
   output logic [15:0] crc_o
);

   logic [15:0] c;

   // Reflected polynomial, one data byte per step, one bit per shift
   always_comb begin
      c = crc_i ^ {8'h00, data_i};
      for (int b = 0; b < 8; b++) begin
         if (c[0]) begin
            c = (c >> 1) ^ `MBSF_CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      crc_o = c;
   end

endmodule : mbsf_crc16_step
`default_nettype wire

// ---- mbsf_server_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mbsf_params.svh"

module mbsf_server_framer #(
   parameter int unsigned ASCII_GAP_CYCLES = `MBSF_ASCII_GAP_CYCLES,
   parameter int unsigned RTU_T15_CYCLES = `MBSF_RTU_T15_CYCLES,
   parameter int unsigned RTU_T35_CYCLES = `MBSF_RTU_T35_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Link mode and identity
   input wire logic ascii_mode_i,
   input wire logic [7:0] station_i,
   // Server condition
   input wire logic server_fault_i,
   input wire logic server_busy_i,
   // Received characters
   input wire mbsf_pkg::mbsf_char_t rx_i,
   // Transmitted characters
   output mbsf_pkg::mbsf_char_t tx_o,
   input wire logic tx_ready_i,
   // Coil image read port
   output logic [15:0] coil_addr_o,
   input wire logic [7:0] coil_data_i,
   // Decoded requests handed to the application
   output logic req_valid_o,
   output mbsf_pkg::mbsf_req_t req_o
);

   mbsf_pkg::mbsf_state_t s, next_s;

   logic [7:0] ch, rx_byte, cur_byte, tx_char, ex_code, byte_cnt, blen, coil_mask;
   logic [7:0] func;
   logic [4:0] hv;
   logic [15:0] crc_base, rx_crc_next, tx_crc_next, q_lim, addr, qty;
   logic [16:0] addr_end;
   logic byte_ev, fresh, end_ev, good, match, load, legal, need_q, slot, byte_done;

   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= `MBSF_CH_0 && c <= `MBSF_CH_9) begin
         return {1'b1, 4'(c - `MBSF_CH_0)};
      end
      if (c >= `MBSF_CH_UA && c <= `MBSF_CH_UF) begin
         return {1'b1, 4'(c - `MBSF_HEX_ALPHA_OFS)};
      end
      if (c >= `MBSF_CH_LA && c <= `MBSF_CH_LF_HEX) begin
         return {1'b1, 4'(c - `MBSF_HEX_LOWER_OFS)};
      end
      return 5'h00;
   endfunction : hex_val

   function automatic logic [7:0] hex_char(input logic [3:0] v);
      if (v < 4'hA) begin
         return `MBSF_CH_0 + {4'h0, v};
      end
      return `MBSF_HEX_ALPHA_OFS + {4'h0, v};
   endfunction : hex_char

   mbsf_crc16_step u_rx_crc (
      .crc_i(crc_base),
      .data_i(rx_byte),
      .crc_o(rx_crc_next)
   );

   mbsf_crc16_step u_tx_crc (
      .crc_i(s.tcrc),
      .data_i(cur_byte),
      .crc_o(tx_crc_next)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Receive framing and request decode

   always_comb begin
      ch = ascii_mode_i ? {1'b0, rx_i.data[6:0]} : rx_i.data;
      hv = hex_val(ch);
      rx_byte = ascii_mode_i ? {s.hi_nib, hv[3:0]} : ch;
      // RTU frame closes after 1.5 character times of silence
      end_ev = ascii_mode_i ? (rx_i.valid && s.rx_on && s.got_cr && ch == `MBSF_CH_LF)
                            : (s.rx_on && s.gap == 32'(RTU_T15_CYCLES));
      fresh = !s.rx_on || end_ev;
      blen = (!ascii_mode_i && fresh) ? 8'h00 : s.len;
      crc_base = fresh ? `MBSF_CRC_PRESET : s.crc;
      byte_ev = rx_i.valid && (ascii_mode_i ? (s.rx_on && !s.got_cr && hv[4] && s.hi_ok)
                                            : 1'b1);
      // Sum of content plus its two's complement is zero; CRC residue is zero
      good = ascii_mode_i
             ? (s.lrc == 8'h00 && !s.hi_ok && s.len >= `MBSF_HDR_LEN + `MBSF_ASCII_CHK_LEN)
             : (s.crc == 16'h0000 && s.len >= `MBSF_HDR_LEN + `MBSF_RTU_CHK_LEN);
      match = s.buf_b[0] == station_i && station_i >= `MBSF_STATION_MIN &&
              station_i <= `MBSF_STATION_MAX;
      // Frames arriving while a reply is under way are dropped
      load = end_ev && good && match && s.txs == mbsf_pkg::T_IDLE;
      func = s.buf_b[1];
      addr = {s.buf_b[2], s.buf_b[3]};
      qty = {s.buf_b[4], s.buf_b[5]};
      legal = 1'b1;
      need_q = 1'b1;
      q_lim = 16'h0000;
      case (func)
         `MBSF_FC_READ_COILS, `MBSF_FC_READ_INPUTS: q_lim = `MBSF_MAX_BITS_READ;
         `MBSF_FC_READ_HOLDING, `MBSF_FC_READ_INREGS: q_lim = `MBSF_MAX_WORDS_READ;
         `MBSF_FC_WRITE_COIL, `MBSF_FC_WRITE_REG: need_q = 1'b0;
         `MBSF_FC_WRITE_COILS: q_lim = `MBSF_MAX_BITS_WRITE;
         `MBSF_FC_WRITE_REGS: q_lim = `MBSF_MAX_WORDS_WRITE;
         default: legal = 1'b0;
      endcase
      // Coil image covers data addresses 0 to COIL_COUNT-1
      addr_end = {1'b0, addr} + {1'b0, qty};
      if (!legal) begin
         ex_code = `MBSF_EXC_ILLEGAL_FUNC;
      end else if (need_q && (qty == 16'h0000 || qty > q_lim)) begin
         ex_code = `MBSF_EXC_BAD_VALUE;
      end else if (func == `MBSF_FC_READ_COILS && addr_end > {1'b0, `MBSF_COIL_COUNT}) begin
         ex_code = `MBSF_EXC_BAD_ADDR;
      end else if (server_fault_i) begin
         ex_code = `MBSF_EXC_SERVER_FAULT;
      end else if (server_busy_i) begin
         ex_code = `MBSF_EXC_BUSY_RETRY;
      end else begin
         ex_code = `MBSF_EXC_NONE;
      end
      byte_cnt = 8'((qty + 16'h0007) >> 3);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reply byte source

   always_comb begin
      coil_mask = (s.rsp_qty >= 16'h0008) ? 8'hFF : ~(8'hFF << s.rsp_qty[2:0]);
      cur_byte = 8'h00;
      unique case (s.txs)
         mbsf_pkg::T_HEAD: begin
            if (s.idx == 8'h00) begin
               cur_byte = s.rsp_sta;
            end else if (s.idx == 8'h01) begin
               cur_byte = s.rsp_func;
            end else begin
               cur_byte = s.rsp_code;
            end
         end
         // Unused high bits of the last coil byte go out as zero
         mbsf_pkg::T_COIL: cur_byte = coil_data_i & coil_mask;
         mbsf_pkg::T_CHK: begin
            if (ascii_mode_i) begin
               cur_byte = 8'(~s.tlrc + 8'h01);
            end else begin
               cur_byte = (s.idx == 8'h00) ? s.tcrc[7:0] : s.tcrc[15:8];
            end
         end
         mbsf_pkg::T_IDLE, mbsf_pkg::T_GAP, mbsf_pkg::T_COLON, mbsf_pkg::T_CR,
         mbsf_pkg::T_LF: cur_byte = 8'h00;
      endcase
      tx_char = ascii_mode_i ? hex_char(s.nib ? cur_byte[3:0] : cur_byte[7:4]) : cur_byte;
      byte_done = !ascii_mode_i || s.nib;
      slot = !s.tx.valid || tx_ready_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_s = s;
      next_s.req_valid = 1'b0;
      if (rx_i.valid) begin
         next_s.gap = 32'h0000_0000;
      end else if (s.gap != 32'hFFFF_FFFF) begin
         next_s.gap = s.gap + 32'h0000_0001;
      end
      if (ascii_mode_i) begin
         if (rx_i.valid) begin
            if (ch == `MBSF_CH_COLON) begin
               // Colon always restarts, so a torn frame resynchronises
               next_s.rx_on = 1'b1;
               next_s.len = 8'h00;
               next_s.hi_ok = 1'b0;
               next_s.got_cr = 1'b0;
               next_s.lrc = 8'h00;
            end else if (s.rx_on) begin
               if (s.got_cr) begin
                  next_s.rx_on = 1'b0;
               end else if (ch == `MBSF_CH_CR) begin
                  next_s.got_cr = 1'b1;
               end else if (!hv[4]) begin
                  next_s.rx_on = 1'b0;
               end else if (!s.hi_ok) begin
                  next_s.hi_nib = hv[3:0];
                  next_s.hi_ok = 1'b1;
               end else begin
                  next_s.hi_ok = 1'b0;
                  next_s.lrc = s.lrc + rx_byte;
               end
            end
         end else if (s.rx_on && s.gap >= 32'(ASCII_GAP_CYCLES)) begin
            next_s.rx_on = 1'b0;
         end
      end else begin
         if (end_ev) begin
            next_s.rx_on = 1'b0;
         end
         if (rx_i.valid) begin
            next_s.rx_on = 1'b1;
            next_s.crc = rx_crc_next;
         end
      end
      if (byte_ev) begin
         if (blen < `MBSF_HDR_LEN) begin
            next_s.buf_b[blen[2:0]] = rx_byte;
         end
         if (blen != 8'hFF) begin
            next_s.len = blen + 8'h01;
         end
      end
      if (load) begin
         next_s.rsp_sta = s.buf_b[0];
         if (ex_code != `MBSF_EXC_NONE || func == `MBSF_FC_READ_COILS) begin
            next_s.rsp_exc = ex_code != `MBSF_EXC_NONE;
            next_s.rsp_func = (ex_code != `MBSF_EXC_NONE) ? (func | `MBSF_ERR_FLAG) : func;
            next_s.rsp_code = (ex_code != `MBSF_EXC_NONE) ? ex_code : byte_cnt;
            next_s.rsp_qty = qty;
            next_s.coil_addr = addr;
            next_s.tcrc = `MBSF_CRC_PRESET;
            next_s.tlrc = 8'h00;
            next_s.idx = 8'h00;
            next_s.nib = 1'b0;
            // RTU reply waits out 3.5 character times after the request
            next_s.txs = ascii_mode_i ? mbsf_pkg::T_COLON : mbsf_pkg::T_GAP;
         end else begin
            // Other accepted requests are served by the application
            next_s.req_valid = 1'b1;
            next_s.req.func = func;
            next_s.req.addr = addr;
            next_s.req.qty = qty;
         end
      end
      if (slot) begin
         next_s.tx.valid = 1'b0;
         unique case (s.txs)
            mbsf_pkg::T_IDLE: next_s.tx.valid = 1'b0;
            mbsf_pkg::T_GAP: begin
               if (s.gap >= 32'(RTU_T35_CYCLES)) begin
                  next_s.txs = mbsf_pkg::T_HEAD;
               end
            end
            mbsf_pkg::T_COLON: begin
               next_s.tx.valid = 1'b1;
               next_s.tx.data = `MBSF_CH_COLON;
               next_s.txs = mbsf_pkg::T_HEAD;
            end
            mbsf_pkg::T_HEAD, mbsf_pkg::T_COIL, mbsf_pkg::T_CHK: begin
               next_s.tx.valid = 1'b1;
               next_s.tx.data = tx_char;
               next_s.nib = !byte_done;
               if (byte_done) begin
                  next_s.idx = s.idx + 8'h01;
                  if (s.txs != mbsf_pkg::T_CHK) begin
                     next_s.tcrc = tx_crc_next;
                     next_s.tlrc = s.tlrc + cur_byte;
                  end
                  if (s.txs == mbsf_pkg::T_HEAD && s.idx == 8'h02) begin
                     next_s.idx = 8'h00;
                     next_s.txs = s.rsp_exc ? mbsf_pkg::T_CHK : mbsf_pkg::T_COIL;
                  end else if (s.txs == mbsf_pkg::T_COIL) begin
                     next_s.coil_addr = s.coil_addr + 16'h0008;
                     next_s.rsp_qty = (s.rsp_qty > 16'h0008) ? s.rsp_qty - 16'h0008 : 16'h0000;
                     if (s.rsp_qty <= 16'h0008) begin
                        next_s.idx = 8'h00;
                        next_s.txs = mbsf_pkg::T_CHK;
                     end
                  end else if (s.txs == mbsf_pkg::T_CHK &&
                               (ascii_mode_i || s.idx == 8'h01)) begin
                     next_s.txs = ascii_mode_i ? mbsf_pkg::T_CR : mbsf_pkg::T_IDLE;
                  end
               end
            end
            mbsf_pkg::T_CR: begin
               next_s.tx.valid = 1'b1;
               next_s.tx.data = `MBSF_CH_CR;
               next_s.txs = mbsf_pkg::T_LF;
            end
            mbsf_pkg::T_LF: begin
               next_s.tx.valid = 1'b1;
               next_s.tx.data = `MBSF_CH_LF;
               next_s.txs = mbsf_pkg::T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tx_o = s.tx;
   assign coil_addr_o = s.coil_addr;
   assign req_valid_o = s.req_valid;
   assign req_o = s.req;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence cr_taken;
      ascii_mode_i && s.tx.valid && tx_ready_i && s.tx.data == `MBSF_CH_CR;
   endsequence

   sequence lf_offered;
      s.tx.valid && s.tx.data == `MBSF_CH_LF;
   endsequence

   chk_crlf_order: assert property (cr_taken |=> lf_offered)
      else $error("CR not followed by LF");
   chk_exc_func: assert property (load && ex_code != `MBSF_EXC_NONE |=>
      s.rsp_exc && s.rsp_func == ($past(s.buf_b[1]) | `MBSF_ERR_FLAG))
      else $error("exception function code wrong");
   chk_exc_code_range: assert property (s.rsp_exc |-> s.rsp_code >= `MBSF_EXC_ILLEGAL_FUNC &&
      s.rsp_code <= `MBSF_EXC_DELAYED)
      else $error("exception code out of range");
   chk_coil_err_code: assert property (load && s.buf_b[1] == `MBSF_FC_READ_COILS &&
      ex_code != `MBSF_EXC_NONE |=> s.rsp_func == `MBSF_READ_COILS_ERR)
      else $error("read coils error code wrong");
   chk_ascii_break: assert property (ascii_mode_i && !rx_i.valid && s.rx_on &&
      s.gap >= 32'(ASCII_GAP_CYCLES) |=> !s.rx_on)
      else $error("ASCII gap did not break frame");
   chk_rtu_frame_end: assert property (!ascii_mode_i && s.rx_on && !rx_i.valid &&
      s.gap == 32'(RTU_T15_CYCLES) |=> !s.rx_on)
      else $error("RTU frame not closed by idle");
   chk_rtu_tx_gap: assert property (!ascii_mode_i && $rose(s.tx.valid) |->
      $past(s.gap, 2) >= 32'(RTU_T35_CYCLES))
      else $error("RTU reply sent too soon");
   chk_reply_station: assert property (load |=> s.rsp_sta == $past(station_i) &&
      s.rsp_sta >= `MBSF_STATION_MIN && s.rsp_sta <= `MBSF_STATION_MAX)
      else $error("reply station wrong");
   chk_ascii_seven_bit: assert property (ascii_mode_i && s.tx.valid |-> !s.tx.data[7])
      else $error("ASCII character wider than 7 bits");
   chk_coil_qty: assert property (load && s.buf_b[1] == `MBSF_FC_READ_COILS &&
      ex_code == `MBSF_EXC_NONE |=> s.rsp_code >= 8'h01 && s.rsp_code <= 8'hFA)
      else $error("read coils byte count out of range");

endmodule : mbsf_server_framer
`default_nettype wire

// ---- mbsf_client_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbsf_client_model (
   // Clock and stall request
   input wire logic core_clk_i,
   input wire logic stall_i,
   // Link toward the server
   output var mbsf_pkg::mbsf_char_t rx_o,
   input wire mbsf_pkg::mbsf_char_t tx_i,
   output var logic tx_ready_o
);
   logic [7:0] got[$];
   initial begin
      rx_o = '0;
      tx_ready_o = 1'b0;
   end
   always @(posedge core_clk_i) begin
      if (tx_i.valid === 1'b1 && tx_ready_o) got.push_back(tx_i.data);
      tx_ready_o <= !stall_i;
   end
   // Released line shows the inverse of the last char, never a stale copy
   task automatic send(input logic [7:0] w[$], input int gap_at, input int gap_len);
      foreach (w[i]) begin
         if (i == gap_at) begin
            @(posedge core_clk_i);
            rx_o <= {1'b0, ~w[i - 1]};
            repeat (gap_len - 1) @(posedge core_clk_i);
         end
         @(posedge core_clk_i);
         rx_o <= {1'b1, w[i]};
      end
      @(posedge core_clk_i);
      rx_o <= {1'b0, ~w[w.size() - 1]};
   endtask : send
endmodule : mbsf_client_model
`default_nettype wire

// ---- mbsf_server_framer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbsf_server_framer_tb;
   // Short counts keep the run small
   localparam int A_GAP = 200;
   localparam int T15 = 20;
   localparam int T35 = 50;
   typedef logic [7:0] mbsf_bq_t[$];
   logic core_clk_i, reset_i, ascii_mode_i, server_fault_i, server_busy_i, tx_ready_i;
   logic stall = 1'b0;
   logic slow;
   logic [7:0] station_i, coil_data_i;
   logic [15:0] coil_addr_o;
   logic req_valid_o;
   mbsf_pkg::mbsf_char_t rx_i, tx_o;
   mbsf_pkg::mbsf_req_t req_o, last_req;
   int errors = 0;
   int tests_run = 0;
   int req_cnt = 0;
   int cyc = 0;
   int seed = 32'h931B;
   logic [7:0] fl [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};
   logic [39:0] tbl [13] = '{40'h07_0000_0001, 40'h01_0000_0000, 40'h01_0000_07D1,
      40'h02_0000_07D0, 40'h03_0000_007E, 40'h04_0000_007D, 40'h0F_0000_07B1,
      40'h10_0000_0079, 40'h10_0000_0078, 40'h05_0010_FF00, 40'h06_0020_1234,
      40'h01_07F0_0011, 40'h01_07F0_0010};

   mbsf_server_framer #(.ASCII_GAP_CYCLES(A_GAP), .RTU_T15_CYCLES(T15), .RTU_T35_CYCLES(T35))
   i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ascii_mode_i(ascii_mode_i),
      .station_i(station_i), .server_fault_i(server_fault_i), .server_busy_i(server_busy_i),
      .rx_i(rx_i), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .coil_addr_o(coil_addr_o),
      .coil_data_i(coil_data_i), .req_valid_o(req_valid_o), .req_o(req_o));
   mbsf_client_model i_client (.core_clk_i(core_clk_i), .stall_i(stall), .rx_o(rx_i),
      .tx_i(tx_o), .tx_ready_o(tx_ready_i));

   function automatic logic cb(logic [15:0] a);
      return a[0] ^ a[3] ^ a[5];
   endfunction : cb
   function automatic logic [7:0] hx(logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
   endfunction : hx
   function automatic mbsf_bq_t enc(logic asc, mbsf_bq_t q);
      mbsf_bq_t r;
      logic [15:0] c;
      logic [7:0] s;
      c = 16'hFFFF;
      s = 8'h00;
      foreach (q[i]) begin
         s += q[i];
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      if (!asc) return {q, c[7:0], c[15:8]};
      q.push_back(8'h00 - s);
      r.push_back(8'h3A);
      foreach (q[i]) r = {r, hx(q[i][7:4]), hx(q[i][3:0])};
      return {r, 8'h0D, 8'h0A};
   endfunction : enc
   function automatic mbsf_bq_t reply(logic [7:0] f, logic [15:0] a, logic [15:0] n);
      mbsf_bq_t r;
      logic [7:0] e;
      logic [7:0] b;
      logic [15:0] lim;
      lim = (f < 8'h03) ? 16'h07D0 : (f < 8'h05) ? 16'h007D : (f == 8'h0F) ? 16'h07B0 : 16'h0078;
      e = 8'h00;
      if (!(f inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10})) e = 8'h01;
      else if (f != 8'h05 && f != 8'h06 && (n == 16'h0000 || n > lim)) e = 8'h03;
      else if (f == 8'h01 && {1'b0, a} + {1'b0, n} > 17'h00800) e = 8'h02;
      else if (server_fault_i) e = 8'h04;
      else if (server_busy_i) e = 8'h05;
      if (e != 8'h00) return {station_i, f | 8'h80, e};
      if (f != 8'h01) return {};
      r = {station_i, f, 8'((n + 16'h0007) >> 3)};
      for (int k = 0; k < (n + 7) / 8; k++) begin
         b = 8'h00;
         for (int j = 0; j < 8; j++) if (8 * k + j < n) b[j] = cb(a + 16'(8 * k + j));
         r.push_back(b);
      end
      return r;
   endfunction : reply

   always_comb for (int j = 0; j < 8; j++) coil_data_i[j] = cb(coil_addr_o + 16'(j));

   task automatic cmp_q(string nm, mbsf_bq_t e, mbsf_bq_t g);
      bit ok;
      ok = e.size() == g.size();
      foreach (e[i]) if (ok && e[i] !== g[i]) ok = 1'b0;
      tests_run++;
      if (!ok) begin
         errors++;
         $display("Error %s expected %p seen %p", nm, e, g);
      end
   endtask : cmp_q
   task automatic cmp_v(string nm, logic [63:0] e, logic [63:0] g);
      tests_run++;
      if (e !== g) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_v
   task automatic results();
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   // One request, then wait out the reply and a full frame gap
   task automatic xact(logic asc, logic [7:0] st, logic [7:0] f, logic [15:0] a,
         logic [15:0] n, int bad);
      mbsf_bq_t w;
      mbsf_bq_t r;
      int t;
      int rc;
      logic ours;
      logic acc;
      ours = st == station_i && station_i inside {[8'h01:8'h1F]} && bad == 0;
      r = reply(f, a, n);
      acc = ours && r.size() == 0;
      if (!ours) r = {};
      if (r.size() > 0) r = enc(asc, r);
      w = {st, f, a[15:8], a[7:0], n[15:8], n[7:0]};
      w = enc(asc, w);
      if (asc && st == 8'h1F) foreach (w[i]) if (w[i] inside {[8'h41:8'h46]}) w[i] += 8'h20;
      if (bad == 1) w[w.size() - 3] ^= 8'h01;
      rc = req_cnt;
      ascii_mode_i <= asc;
      i_client.got.delete();
      i_client.send(w, bad == 2 ? 3 : -1, asc ? A_GAP + 5 : T15 + 3);
      for (t = 0; t < 3000 && i_client.got.size() < r.size(); t++) @(posedge core_clk_i);
      repeat (T35 + 40) @(posedge core_clk_i);
      cmp_q("reply", r, i_client.got);
      cmp_v("req_count", 64'(rc + int'(acc)), 64'(req_cnt));
      if (acc) cmp_v("req_fields", 64'({f, a, n}), 64'(last_req));
   endtask : xact

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      stall <= slow && ($random(seed) % 2 != 0);
      if (req_valid_o === 1'b1) begin
         req_cnt++;
         last_req = req_o;
      end
      cyc++;
      // About 8000 cycles are needed; far beyond that means a hang
      if (cyc == 60000) begin
         errors++;
         results();
      end
   end

   initial begin
      logic [31:0] r;
      reset_i = 1'b1;
      ascii_mode_i = 1'b0;
      station_i = 8'h05;
      server_fault_i = 1'b0;
      server_busy_i = 1'b0;
      slow = 1'b0;
      repeat (6) @(posedge core_clk_i);
      cmp_v("reset_out", 64'h0, 64'({tx_o, coil_addr_o, req_valid_o}));
      reset_i <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         xact(m[0], 8'h05, 8'h01, 16'h0013, 16'h0013, 0);
         foreach (tbl[i]) xact(m[0], 8'h05, tbl[i][39:32], tbl[i][31:16], tbl[i][15:0], 0);
         for (int fb = 1; fb < 4; fb++) begin
            server_fault_i <= fb[0];
            server_busy_i <= fb[1];
            @(posedge core_clk_i);
            xact(m[0], 8'h05, 8'h03, 16'h0000, 16'h0001, 0);
         end
         server_fault_i <= 1'b0;
         server_busy_i <= 1'b0;
         @(posedge core_clk_i);
         xact(m[0], 8'h00, 8'h01, 16'h0000, 16'h0008, 0);
         xact(m[0], 8'h06, 8'h01, 16'h0000, 16'h0008, 0);
         xact(m[0], 8'h05, 8'h01, 16'h0000, 16'h0008, 1);
         xact(m[0], 8'h05, 8'h01, 16'h0000, 16'h0008, 2);
         station_i <= 8'h1F;
         @(posedge core_clk_i);
         xact(m[0], 8'h1F, 8'h01, 16'h07F8, 16'h0008, 0);
         station_i <= 8'h20;
         @(posedge core_clk_i);
         xact(m[0], 8'h20, 8'h01, 16'h0000, 16'h0008, 0);
         station_i <= 8'h00;
         @(posedge core_clk_i);
         xact(m[0], 8'h00, 8'h01, 16'h0000, 16'h0008, 0);
         station_i <= 8'h05;
         @(posedge core_clk_i);
         slow = 1'b1;
         repeat (8) begin
            r = $random(seed);
            xact(m[0], 8'h05, fl[r[2:0]], {5'h00, r[18:8]}, {11'h000, r[23:19]} + 16'h0001, 0);
         end
         slow = 1'b0;
      end
      results();
   end
endmodule : mbsf_server_framer_tb
`default_nettype wire
